// [design/pfsb_pkg.sv]
// shared constants for the pin function select bank
package pfsb_pkg;
    // -----------------------------------------------------------------
    // register map (byte addresses on the word bus)
    // -----------------------------------------------------------------
    localparam logic [7:0]  PFSB_OFF_UNLOCK     = 8'h00;
    localparam logic [7:0]  PFSB_OFF_GPSEL6     = 8'h04;
    localparam logic [7:0]  PFSB_OFF_ALT0       = 8'h08;
    localparam logic [7:0]  PFSB_OFF_ALT1       = 8'h0C;
    localparam logic [7:0]  PFSB_OFF_ALT2       = 8'h10;
    // -----------------------------------------------------------------
    // reset values and unlock key
    // -----------------------------------------------------------------
    localparam logic [31:0] PFSB_RST_GPSEL6     = 32'h0000_0000;
    localparam logic [31:0] PFSB_RST_ALT        = 32'h0000_0000;
    localparam logic [31:0] PFSB_UNLOCK_KEY_DEF = 32'h0000_5A5A;
    localparam logic [31:0] PFSB_UNDEF_DATA     = 32'h0000_0000;
    // -----------------------------------------------------------------
    // field positions of the gated pin
    // -----------------------------------------------------------------
    localparam int          PFSB_GP6_PIN_BIT    = 25;
    localparam int          PFSB_ALT0_FLD_LSB   = 20;
    localparam int          PFSB_ALT0_FLD_W     = 2;
    // -----------------------------------------------------------------
    // highest legal field code per alt register
    // -----------------------------------------------------------------
    localparam logic [3:0]  PFSB_ALT0_MAX_CODE  = 4'h5;
    localparam logic [3:0]  PFSB_ALT1_MAX_CODE  = 4'h6;
    localparam logic [3:0]  PFSB_ALT2_MAX_CODE  = 4'h7;
    // unlock handshake states
    typedef enum logic [0:0] {PFSB_LOCKED, PFSB_ARMED} pfsb_lock_t;
endpackage

// [design/pfsb_sel_reg.sv]
// one lockable select register with byte lanes
`timescale 1ns/1ps
module pfsb_sel_reg #(
    parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic        wr_in,
    input  wire logic [3:0]  sel_in,
    input  wire logic [31:0] data_in,
    output logic      [31:0] q_out
);
    // -----------------------------------------------------------------
    // storage, written only when the bank grants the write
    // -----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            q_out <= RST_VAL;
        end else if (ce_in && wr_in) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_in[b]) begin
                    q_out[8*b +: 8] <= data_in[8*b +: 8];
                end
            end
        end
    end
endmodule

// [design/pfsb_top.sv]
// pin function select bank: unlock key, gpio select six, three alt selects
//
// The Wishbone interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// What this block does
// - select bit 0 gives the pin to gpio, 1 to a peripheral
// - gpio select bit 25 set hands pin to alt zero field 21:20
// - three alt select registers, 32-bit read/write, reset to zero
// - alt zero field codes 0-5 legal, 6-15 prohibited
// - alt one field codes 0-6 legal, 7-15 prohibited
// - alt two field codes 0-7 legal, 8-15 prohibited
// - gpio select six is 32-bit read/write, resets to zero
module pfsb_top
    import pfsb_pkg::*;
#(
    parameter logic [31:0] UNLOCK_KEY = pfsb_pkg::PFSB_UNLOCK_KEY_DEF
) (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        CE_IN,
    input  wire logic        WB_CYC_IN,
    input  wire logic        WB_STB_IN,
    input  wire logic        WB_WE_IN,
    input  wire logic [7:0]  WB_ADR_IN,
    input  wire logic [3:0]  WB_SEL_IN,
    input  wire logic [31:0] WB_DAT_IN,
    output logic      [31:0] WB_DAT_OUT,
    output logic             WB_ACK_OUT,
    output logic             PIN_PERIPH_EN_OUT,
    output logic      [1:0]  PIN_ALT_FUNC_OUT,
    output logic             WRITE_DROPPED_OUT,
    output logic             CODE_ILLEGAL_OUT
);
    import pfsb_pkg::*;

    // -----------------------------------------------------------------
    // bus decode
    // -----------------------------------------------------------------
    logic        req;
    logic        wr_acc;
    logic        hit_unlock;
    logic        hit_sel;
    logic        grant;
    logic [31:0] gpsel6_q;
    logic [31:0] alt0_q;
    logic [31:0] alt1_q;
    logic [31:0] alt2_q;
    pfsb_lock_t  lock_reg;
    pfsb_lock_t  lock_next;
    // per-register write strobes and per-register code flags
    logic        wr_gpsel6;
    logic        wr_alt0;
    logic        wr_alt1;
    logic        wr_alt2;
    logic        bad_alt0;
    logic        bad_alt1;
    logic        bad_alt2;
    logic        bad_gp6;

    // a new request is one not yet acked; ack drops the cycle after
    assign req        = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
    assign wr_acc     = req && WB_WE_IN;
    assign hit_unlock = WB_ADR_IN == PFSB_OFF_UNLOCK;
    assign hit_sel    = WB_ADR_IN == PFSB_OFF_GPSEL6 || WB_ADR_IN == PFSB_OFF_ALT0
                     || WB_ADR_IN == PFSB_OFF_ALT1   || WB_ADR_IN == PFSB_OFF_ALT2;
    assign grant      = wr_acc && hit_sel && lock_reg == PFSB_ARMED;

    // -----------------------------------------------------------------
    // per-register write strobes
    // -----------------------------------------------------------------
    // one hot because the offsets differ; a refused write never raises
    // a strobe, so no lane of a locked register can move
    assign wr_gpsel6  = grant && WB_ADR_IN == PFSB_OFF_GPSEL6;
    assign wr_alt0    = grant && WB_ADR_IN == PFSB_OFF_ALT0;
    assign wr_alt1    = grant && WB_ADR_IN == PFSB_OFF_ALT1;
    assign wr_alt2    = grant && WB_ADR_IN == PFSB_OFF_ALT2;

    // -----------------------------------------------------------------
    // unlock state: armed only by the bus write right before
    // -----------------------------------------------------------------
    always_comb begin
        lock_next = lock_reg;
        if (req) begin
            // any other access in between disarms, so "immediately" is strict
            if (wr_acc && hit_unlock && WB_DAT_IN == UNLOCK_KEY && WB_SEL_IN == 4'hF) begin
                lock_next = PFSB_ARMED;
            end else begin
                lock_next = PFSB_LOCKED;
            end
        end
        case (lock_next)
            PFSB_LOCKED: lock_next = PFSB_LOCKED;
            PFSB_ARMED:  lock_next = PFSB_ARMED;
            default:     lock_next = PFSB_LOCKED;
        endcase
    end

    // the key itself is not stored: only the one-bit armed state survives,
    // so a reset between key and select write leaves the bank locked
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            lock_reg <= PFSB_LOCKED;
        end else if (CE_IN) begin
            lock_reg <= lock_next;
        end
    end

    // -----------------------------------------------------------------
    // select registers
    // -----------------------------------------------------------------
    pfsb_sel_reg #(.RST_VAL(PFSB_RST_GPSEL6)) u_gpsel6 (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .wr_in    (wr_gpsel6),
        .sel_in   (WB_SEL_IN),
        .data_in  (WB_DAT_IN),
        .q_out    (gpsel6_q)
    );
    pfsb_sel_reg #(.RST_VAL(PFSB_RST_ALT)) u_alt0 (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .wr_in    (wr_alt0),
        .sel_in   (WB_SEL_IN),
        .data_in  (WB_DAT_IN),
        .q_out    (alt0_q)
    );
    pfsb_sel_reg #(.RST_VAL(PFSB_RST_ALT)) u_alt1 (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .wr_in    (wr_alt1),
        .sel_in   (WB_SEL_IN),
        .data_in  (WB_DAT_IN),
        .q_out    (alt1_q)
    );
    pfsb_sel_reg #(.RST_VAL(PFSB_RST_ALT)) u_alt2 (
        .clk_in   (CORE_CLK_IN),
        .rst_n_in (RST_N_IN),
        .ce_in    (CE_IN),
        .wr_in    (wr_alt2),
        .sel_in   (WB_SEL_IN),
        .data_in  (WB_DAT_IN),
        .q_out    (alt2_q)
    );

    // -----------------------------------------------------------------
    // bus answer: one-cycle ack, unmapped reads zero, writes ignored
    // -----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            WB_ACK_OUT <= 1'b0;
            WB_DAT_OUT <= PFSB_UNDEF_DATA;
        end else if (CE_IN) begin
            WB_ACK_OUT <= req;
            // writes leave the read word alone, so the last read stays visible
            if (req && !WB_WE_IN) begin
                case (WB_ADR_IN)
                    PFSB_OFF_GPSEL6: WB_DAT_OUT <= gpsel6_q;
                    PFSB_OFF_ALT0:   WB_DAT_OUT <= alt0_q;
                    PFSB_OFF_ALT1:   WB_DAT_OUT <= alt1_q;
                    PFSB_OFF_ALT2:   WB_DAT_OUT <= alt2_q;
                    // unlock key is write-only so it cannot be sniffed
                    default:         WB_DAT_OUT <= PFSB_UNDEF_DATA;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // status: dropped write pulse, sticky-free illegal code level
    // -----------------------------------------------------------------
    function automatic logic nib_bad(input logic [31:0] v, input logic [3:0] mx);
        logic bad;
        bad = 1'b0;
        for (int n = 0; n < 8; n++) begin
            if (v[4*n +: 4] > mx) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    // per-register flags kept apart so each can be probed on its own
    assign bad_alt0 = nib_bad(alt0_q, PFSB_ALT0_MAX_CODE);
    assign bad_alt1 = nib_bad(alt1_q, PFSB_ALT1_MAX_CODE);
    assign bad_alt2 = nib_bad(alt2_q, PFSB_ALT2_MAX_CODE);
    assign bad_gp6  = |gpsel6_q[31:PFSB_GP6_PIN_BIT+1];

    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            WRITE_DROPPED_OUT <= 1'b0;
            CODE_ILLEGAL_OUT  <= 1'b0;
        end else if (CE_IN) begin
            WRITE_DROPPED_OUT <= wr_acc && hit_sel && lock_reg != PFSB_ARMED;
            // nibble-wise check against each register's own max code, plus any
            // gpio select six bit above 25; a cheap guard, not exact
            CODE_ILLEGAL_OUT  <= bad_alt0
                              || bad_alt1
                              || bad_alt2
                              || bad_gp6;
        end
    end

    // -----------------------------------------------------------------
    // pin routing for the gated pin
    // -----------------------------------------------------------------
    // taken from the stored word, never from bus data, so the pin cannot
    // see a half-written word; costs one cycle of lag after the ack
    always_ff @(posedge CORE_CLK_IN) begin
        if (!RST_N_IN) begin
            PIN_PERIPH_EN_OUT <= 1'b0;
            PIN_ALT_FUNC_OUT  <= 2'h0;
        end else if (CE_IN) begin
            PIN_PERIPH_EN_OUT <= gpsel6_q[PFSB_GP6_PIN_BIT];
            // function code only meaningful in peripheral mode
            PIN_ALT_FUNC_OUT  <= gpsel6_q[PFSB_GP6_PIN_BIT]
                ? alt0_q[PFSB_ALT0_FLD_LSB +: PFSB_ALT0_FLD_W] : 2'h0;
        end
    end
endmodule

// [verif/pfsb_checker.sv]
// checker for the pin function select bank
`timescale 1ns/1ps
module pfsb_checker #(
    parameter logic [31:0] UNLOCK_KEY = pfsb_pkg::PFSB_UNLOCK_KEY_DEF
) (
    input wire logic        CORE_CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        CE_IN,
    input wire logic        WB_CYC_IN,
    input wire logic        WB_STB_IN,
    input wire logic        WB_WE_IN,
    input wire logic [7:0]  WB_ADR_IN,
    input wire logic [3:0]  WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic        WB_ACK_OUT,
    input wire logic        PIN_PERIPH_EN_OUT,
    input wire logic [1:0]  PIN_ALT_FUNC_OUT,
    input wire logic        WRITE_DROPPED_OUT,
    input wire logic        CODE_ILLEGAL_OUT
);
    import pfsb_pkg::*;
    // ----------
    // bus and pins
    // ----------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    // taken requests and read answers
    wire logic bus_req = WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT && CE_IN;
    wire logic rd_ack  = WB_ACK_OUT && !WB_WE_IN;
    a_ack_next: assert property (bus_req |=> WB_ACK_OUT) else $error("late ack");
    a_ack_single: assert property (WB_ACK_OUT && CE_IN |=> !WB_ACK_OUT)
        else $error("long ack");
    a_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(WB_STB_IN))
        else $error("ack without strobe");
    a_gpio_alt_zero: assert property (!PIN_PERIPH_EN_OUT |-> PIN_ALT_FUNC_OUT == 2'h0)
        else $error("alt code in gpio mode");
    a_en_from_reg: assert property (rd_ack && WB_ADR_IN == PFSB_OFF_GPSEL6
        |-> PIN_PERIPH_EN_OUT == WB_DAT_OUT[25]) else $error("pin mode off");
    a_alt_from_reg: assert property (rd_ack && WB_ADR_IN == PFSB_OFF_ALT0
        && PIN_PERIPH_EN_OUT |-> PIN_ALT_FUNC_OUT == WB_DAT_OUT[21:20]) else $error("alt off");
    a_drop_on_ack: assert property (WRITE_DROPPED_OUT |-> WB_ACK_OUT && WB_WE_IN)
        else $error("stray drop");
    a_drop_holds_pin: assert property (WRITE_DROPPED_OUT && CE_IN |=>
        $stable(PIN_PERIPH_EN_OUT) && $stable(PIN_ALT_FUNC_OUT)) else $error("drop moved pin");
    a_unlock_reads_zero: assert property (rd_ack && WB_ADR_IN == PFSB_OFF_UNLOCK
        |-> WB_DAT_OUT == 32'h0) else $error("unlock read nonzero");
    a_reset_clears: assert property (disable iff (1'h0) !RST_N_IN && CE_IN |=>
        !WB_ACK_OUT && !PIN_PERIPH_EN_OUT && !CODE_ILLEGAL_OUT) else $error("reset left state");
    c_dropped: cover property (WRITE_DROPPED_OUT);
    c_periph: cover property ($rose(PIN_PERIPH_EN_OUT));
    c_illegal: cover property ($rose(CODE_ILLEGAL_OUT));
    c_frozen: cover property (WB_CYC_IN && WB_STB_IN && !CE_IN);
endmodule
bind pfsb_top pfsb_checker #(.UNLOCK_KEY(UNLOCK_KEY)) u_chk (.CORE_CLK_IN(CORE_CLK_IN),
    .RST_N_IN(RST_N_IN), .CE_IN(CE_IN), .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN),
    .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN), .WB_SEL_IN(WB_SEL_IN), .WB_DAT_IN(WB_DAT_IN),
    .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT), .PIN_PERIPH_EN_OUT(PIN_PERIPH_EN_OUT),
    .PIN_ALT_FUNC_OUT(PIN_ALT_FUNC_OUT), .WRITE_DROPPED_OUT(WRITE_DROPPED_OUT),
    .CODE_ILLEGAL_OUT(CODE_ILLEGAL_OUT));

// [verif/testbench.sv]
// self-checking bench for the pin function select bank
`timescale 1ns/1ps
module testbench;
    import pfsb_pkg::*;
    // ----------
    // model and bus
    // ----------
    localparam logic [31:0] KEY = 32'h0000_C3C3; // arbitrary key
    logic        clk = 1'h0, rst_n, ce, cyc, stb, we, ack, pen, drp, ill, armed;
    logic [7:0]  adr, offs [6];
    logic [3:0]  sel;
    logic [1:0]  alt;
    logic [31:0] wdat, rdat, r, d, m [1:4];
    int          n_mismatch = 0, cmp_count = 0, seed = 32'h590D9E5E;
    int          hold = 0;
    // ce drops inside some requests, for hold cycles, to freeze the answer
    always #2 clk = ~clk;
    pfsb_top #(.UNLOCK_KEY(KEY)) dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
        .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel),
        .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .PIN_PERIPH_EN_OUT(pen),
        .PIN_ALT_FUNC_OUT(alt), .WRITE_DROPPED_OUT(drp), .CODE_ILLEGAL_OUT(ill));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // any field code above its register's last function
    function automatic logic illegal();
        logic f;
        f = m[1][31:26] != 6'h0;
        for (int i = 0; i < 8; i++) begin
            f |= (m[2][4*i+:4] > 4'h5) | (m[3][4*i+:4] > 4'h6) | (m[4][4*i+:4] > 4'h7);
        end
        return f;
    endfunction
    // one classic cycle; the model decides data, drop and pins
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v,
                       input logic [3:0] s);
        int n;
        logic [31:0] e;
        logic dr;
        n = 0;
        e = 32'h0;
        dr = 1'h0;
        if (a >= PFSB_OFF_GPSEL6 && a <= PFSB_OFF_ALT2) begin
            if (!w) e = m[a[4:2]];
            else if (!armed) dr = 1'h1;
            else for (int b = 0; b < 4; b++) if (s[b]) m[a[4:2]][8*b+:8] = v[8*b+:8];
        end
        armed = w && a == PFSB_OFF_UNLOCK && v == KEY && s == 4'hF;
        // each frozen cycle stretches the answer by exactly one cycle
        {cyc, stb, we, adr, sel, wdat, ce} <= {2'h3, w, a, s, v, hold == 0};
        do begin
            @(posedge clk);
            n++;
            if (n == hold) ce <= 1'h1;
        end while (ack !== 1'h1);
        check(n, 2 + hold);
        if (!w) check(rdat, e);
        check({31'h0, drp}, {31'h0, dr});
        {cyc, stb} <= 2'h0;
        repeat (2) @(posedge clk);
        check({31'h0, pen}, {31'h0, m[1][25]});
        check({30'h0, alt}, {30'h0, m[1][25] ? m[2][21:20] : 2'h0});
        check({31'h0, ill}, {31'h0, illegal()});
    endtask
    // reset, read all, random traffic, reset again, read all
    initial begin
        {ce, cyc, stb, we, adr, sel, wdat} <= {1'h1, 47'h0};
        offs = '{PFSB_OFF_UNLOCK, PFSB_OFF_GPSEL6, PFSB_OFF_ALT0, PFSB_OFF_ALT1,
                 PFSB_OFF_ALT2, 8'h14};
        for (int p = 0; p < 2; p++) begin
            m = '{default: 32'h0};
            armed = 1'h0;
            hold = 0;
            rst_n <= 1'h0;
            repeat (20) @(posedge clk);
            rst_n <= 1'h1;
            @(posedge clk);
            for (int k = 0; k < 6; k++) bus(1'h0, offs[k], 32'h0, 4'hF);
            for (int i = 0; i < 400 * (1 - p); i++) begin
                r = $random(seed);
                d = $random(seed) & (r[11] ? 32'h0333_3333 : 32'hFFFF_FFFF);
                hold = r[20] ? r[22:21] : 0;
                if (r[3]) begin
                    bus(1'h1, PFSB_OFF_UNLOCK, r[4] ? KEY : d, r[12] ? 4'hF : 4'h7);
                end
                bus(r[5] | r[13], offs[r[10:8] % 6], d, r[6] ? 4'hF : r[17:14]);
            end
        end
        stop_test();
    end
    // hang guard, well past the expected few thousand cycles
    initial begin
        #(4 * 30000);
        n_mismatch++;
        stop_test();
    end
endmodule
